// file: rtl/osf_filter.sv
`timescale 1ns/1ps
`include "osf_defines.svh"
// What this block does
// - Old results stay readable in output registers while busy is high.
// - Output registers load new averages at busy falling edge.
// - Select 000 none, 001..110 ratio 2..64, 111 invalid.
// - Select latched at busy fall; governs the next conversion only.
// - First sample at trigger rise, rest on internal strobe.
// - N samples per channel averaged, first-order sinc.
// - Averaged result decimated to a 16-bit word.
// - Busy held high for the whole multi-sample conversion.
module osf_filter #(
  parameter int CH         = 8,
  parameter int W          = `OSF_RES_W,
  parameter int STROBE_CYC = `OSF_STROBE_CYC
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            arst_n,
  // Host controls
  input  wire logic            sample_trigger_a,
  input  wire logic            sample_trigger_b,
  input  wire logic [2:0]      oversample_select,
  // Converter core samples, one word per channel
  input  wire logic [CH*W-1:0] conv_data,
  output logic                 conv_start,
  input  wire logic            conv_done,
  // Results and status
  output logic                 busy,
  output logic [CH*W-1:0]      result,
  output logic [2:0]           ratio_log2
);
  // Accumulator guard bits serve up to 64 samples; the strobe timer is 16 bits wide
  if (CH < 1 || W < 2 || STROBE_CYC < 1 || STROBE_CYC > 65535) begin : g_bad_params
    $error("osf_filter: unsupported parameters");
  end

  // Shift follows the ratio of the running conversion, not the one latched at its end
  osf_acc_if #(.CH(CH), .W(W)) acc_bus ();

  osf_acc #(.CH(CH), .W(W)) u_acc (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .bus     (acc_bus)
  );

  // Control state
  osf_pkg::osf_state_e state_r;
  osf_pkg::osf_state_e state_nxt;
  logic [6:0]          left_r;
  logic [6:0]          left_nxt;
  logic                start_r;
  logic                start_nxt;
  logic                busy_fall;
  // Strobe timer
  logic [15:0]         gap_r;
  logic [15:0]         gap_nxt;
  logic                gap_load;
  logic                gap_end;
  // Trigger edge detector
  logic                trig_now;
  logic                trig_r;
  logic                trig_nxt;
  logic                trig_rise;
  // Latched ratio
  logic [2:0]          ratio_r;
  logic [2:0]          ratio_nxt;
  logic [6:0]          n_total;
  // Output data registers
  logic [CH*W-1:0]     result_r;
  logic [CH*W-1:0]     result_nxt;

  // Host ties both triggers when oversampling; either one starts a run
  assign trig_now  = sample_trigger_a | sample_trigger_b;
  assign trig_rise = trig_now & ~trig_r;

  // Reset level equals the idle pin level, so no false edge follows reset
  always_comb begin
    trig_nxt = trig_now;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= trig_nxt;
    end
  end

  // Samples per conversion from the latched ratio
  always_comb begin
    unique case (ratio_r)
      3'h1: n_total = 7'h02;
      3'h2: n_total = 7'h04;
      3'h3: n_total = 7'h08;
      3'h4: n_total = 7'h10;
      3'h5: n_total = 7'h20;
      3'h6: n_total = 7'h40;
      default: n_total = 7'h01;
    endcase
  end

  always_comb begin
    state_nxt     = state_r;
    left_nxt      = left_r;
    start_nxt     = 1'b0;
    gap_load      = 1'b0;
    busy_fall     = 1'b0;
    acc_bus.clear = 1'b0;
    acc_bus.add   = 1'b0;
    unique case (state_r)
      osf_pkg::OSF_IDLE: begin
        // Triggers while busy are ignored; only an idle edge starts a run
        if (trig_rise) begin
          acc_bus.clear = 1'b1;
          left_nxt      = n_total;
          start_nxt     = 1'b1;
          state_nxt     = osf_pkg::OSF_ACC;
        end
      end
      osf_pkg::OSF_ACC: begin
        // Each returned sample joins the running sum
        if (conv_done) begin
          acc_bus.add = 1'b1;
          left_nxt    = left_r - 7'h01;
          gap_load    = 1'b1;
          state_nxt   = (left_r == 7'h01) ? osf_pkg::OSF_DONE : osf_pkg::OSF_WAIT;
        end
      end
      osf_pkg::OSF_WAIT: begin
        // Internal strobe for remaining samples
        if (gap_end) begin
          start_nxt = 1'b1;
          state_nxt = osf_pkg::OSF_ACC;
        end
      end
      osf_pkg::OSF_DONE: begin
        // Busy falls as this cycle ends: results and select move together
        busy_fall = 1'b1;
        state_nxt = osf_pkg::OSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= osf_pkg::OSF_IDLE;
      left_r  <= 7'h00;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      left_r  <= left_nxt;
      start_r <= start_nxt;
    end
  end

  // Strobe timer: gap between a sample and the next start
  // Limitation: the timer loads only on conv_done, so starts never stack up, but a core that never answers stalls the run
  assign gap_end = (gap_r <= 16'h0001);

  always_comb begin
    gap_nxt = gap_r;
    if (gap_load) begin
      gap_nxt = 16'(STROBE_CYC);
    end else if (state_r == osf_pkg::OSF_WAIT && !gap_end) begin
      gap_nxt = gap_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  // Select sampled as busy falls; governs the next conversion only
  // Invalid code is stored as no oversampling, so the output never shows it
  always_comb begin
    ratio_nxt = ratio_r;
    if (busy_fall) begin
      ratio_nxt = (oversample_select == `OSF_SEL_INVALID) ? `OSF_SEL_NONE : oversample_select;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ratio_r <= `OSF_SEL_RST;
    end else begin
      ratio_r <= ratio_nxt;
    end
  end

  // Old results stand for the host to read while busy is high
  always_comb begin
    result_nxt = result_r;
    if (busy_fall) begin
      result_nxt = acc_bus.avg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  assign acc_bus.sample = conv_data;
  assign acc_bus.shift  = ratio_r;

  // Busy is decoded from both state register bits, so it can glitch on the WAIT to ACC step
  assign busy       = (state_r != osf_pkg::OSF_IDLE);
  assign result     = result_r;
  assign conv_start = start_r;
  assign ratio_log2 = ratio_r;
endmodule

// file: rtl/osf_defines.svh
`ifndef OSF_DEFINES_SVH
`define OSF_DEFINES_SVH

// Oversample select codes
`define OSF_SEL_NONE      3'h0
`define OSF_SEL_INVALID   3'h7
// Reset value of the latched select
`define OSF_SEL_RST       3'h0
// Internal sampling strobe spacing, ns, and derived count at 4 ns clock
`define OSF_STROBE_NS     1000
`define OSF_CLK_NS        4
`define OSF_STROBE_CYC    ((`OSF_STROBE_NS + `OSF_CLK_NS - 1) / `OSF_CLK_NS)
// Result width
`define OSF_RES_W         16

`endif

// file: rtl/osf_pkg.sv
package osf_pkg;
  typedef enum logic [1:0] {
    OSF_IDLE,
    OSF_WAIT,
    OSF_ACC,
    OSF_DONE
  } osf_state_e;
endpackage

// file: rtl/osf_acc_if.sv
`timescale 1ns/1ps
interface osf_acc_if #(
  parameter int CH = 8,
  parameter int W  = 16
);
  logic                 clear;
  logic                 add;
  logic [CH*W-1:0]      sample;
  logic [2:0]           shift;
  logic [CH*W-1:0]      avg;

  modport ctrl (output clear, output add, output sample, output shift, input avg);
  modport acc  (input clear, input add, input sample, input shift, output avg);
endinterface

// file: rtl/osf_acc.sv
`timescale 1ns/1ps
`include "osf_defines.svh"
// One accumulator per channel; sum of up to 64 samples needs 6 guard bits
module osf_acc #(
  parameter int CH = 8,
  parameter int W  = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Control side
  osf_acc_if.acc   bus
);
  localparam int AW = W + 6;

  logic signed [AW-1:0] sum_r   [CH];
  logic signed [AW-1:0] sum_nxt [CH];

  always_comb begin
    for (int c = 0; c < CH; c++) begin
      sum_nxt[c] = sum_r[c];
      if (bus.clear) begin
        sum_nxt[c] = '0;
      end else if (bus.add) begin
        sum_nxt[c] = sum_r[c] + AW'($signed(bus.sample[c*W +: W]));
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < CH; c++) begin
        sum_r[c] <= '0;
      end
    end else begin
      sum_r <= sum_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_avg
      logic signed [AW-1:0] shifted;
      // Arithmetic shift keeps sign, truncates toward minus infinity
      assign shifted = sum_r[g] >>> bus.shift;
      assign bus.avg[g*W +: W] = shifted[W-1:0];
    end
  endgenerate
endmodule

// file: verif/osf_core_model.sv
`timescale 1ns/1ps
module osf_core_model #(
  parameter int CH = 8
) (
  input logic             ref_clk,
  input logic             arst_n,
  input logic             conv_start,
  input logic             busy,
  output logic            conv_done,
  output logic [CH*16-1:0] conv_data
);
  logic [1:0] dly_r;
  logic       ph_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_r <= 2'h0;
      conv_done <= 1'b0;
      ph_r <= 1'b0;
    end else begin
      dly_r <= {dly_r[0], conv_start};
      conv_done <= dly_r[1];
      ph_r <= busy & (ph_r ^ conv_done);
    end
  end
  // Alternating samples; word inverted outside done so stale data never matches
  for (genvar c = 0; c < CH; c++) begin : g_ch
    assign conv_data[c*16+:16] = (ph_r ? 16'h0006 : 16'hFFFD - 16'(c)) ^ {16{!conv_done}};
  end
endmodule

// file: verif/osf_filter_monitor.sv
`timescale 1ns/1ps
module osf_filter_monitor #(
  parameter int CH         = 8,
  parameter int W          = 16,
  parameter int STROBE_CYC = 250
) (
  input logic            ref_clk,
  input logic            arst_n,
  input logic            sample_trigger_a,
  input logic            sample_trigger_b,
  input logic [2:0]      oversample_select,
  input logic [CH*W-1:0] conv_data,
  input logic            conv_start,
  input logic            conv_done,
  input logic            busy,
  input logic [CH*W-1:0] result,
  input logic [2:0]      ratio_log2
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  localparam int GAP = STROBE_CYC + 1;
  wire trg = sample_trigger_a | sample_trigger_b;
  sequence s_rise;
    !busy && trg && !$past(trg);
  endsequence
  a_start_trig: assert property (s_rise |=> conv_start && busy)
    else $error("no start after trigger");
  a_res_hold: assert property (busy |-> $stable(result))
    else $error("result moved while busy");
  a_res_load: assert property ($changed(result) |-> $fell(busy))
    else $error("result moved off busy fall");
  a_ratio_hold: assert property ($changed(ratio_log2) |-> $fell(busy))
    else $error("ratio moved off busy fall");
  a_ratio_code: assert property ($fell(busy) |-> ratio_log2 ==
    ($past(oversample_select) == 3'h7 ? 3'h0 : $past(oversample_select))) else $error("bad ratio");
  a_start_busy: assert property (conv_start |-> busy)
    else $error("start while idle");
  a_strobe_gap: assert property (conv_done |-> ##GAP (conv_start || !busy))
    else $error("bad strobe spacing");
  a_busy_end: assert property ($fell(busy) |-> $past(conv_done, 2))
    else $error("busy fell early");
endmodule
bind osf_filter osf_filter_monitor #(.CH(CH), .W(W), .STROBE_CYC(STROBE_CYC)) u_mon (
  .ref_clk(ref_clk), .arst_n(arst_n), .sample_trigger_a(sample_trigger_a),
  .sample_trigger_b(sample_trigger_b), .oversample_select(oversample_select),
  .conv_data(conv_data), .conv_start(conv_start), .conv_done(conv_done),
  .busy(busy), .result(result), .ratio_log2(ratio_log2));

// file: verif/osf_filter_bench.sv
`timescale 1ns/1ps
module osf_filter_bench;
  logic           ref_clk = 0, arst_n = 0, trig = 0;
  logic [2:0]     sel = 3'h0, ratio_log2;
  logic           conv_start, conv_done, busy;
  logic [127:0]   conv_data, result;
  int             failures = 0, num_checks = 0, cur = 0;
  // Minimum trigger period per sample, scaled like the short strobe
  localparam int  TRIG_GAP = 10;
  osf_filter #(.CH(8), .STROBE_CYC(2)) uut (.ref_clk(ref_clk), .arst_n(arst_n),
    .sample_trigger_a(trig), .sample_trigger_b(trig), .oversample_select(sel),
    .conv_data(conv_data), .conv_start(conv_start), .conv_done(conv_done),
    .busy(busy), .result(result), .ratio_log2(ratio_log2));
  osf_core_model #(.CH(8)) core (.ref_clk(ref_clk), .arst_n(arst_n), .conv_start(conv_start),
    .busy(busy), .conv_done(conv_done), .conv_data(conv_data));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Select is wrong at the trigger and right only later, and the trigger toggles while busy
  task automatic conv(input logic [2:0] s);
    int st, w, n;
    st = 0;
    w = 0;
    n = 1 << cur;
    @(posedge ref_clk) #1 sel = ~s;
    trig = 1;
    @(posedge ref_clk) #1 trig = 0;
    sel = s;
    do begin
      st += conv_start;
      trig = w[2];
      @(posedge ref_clk) #1 w++;
    end while (busy === 1'b1 && w < 2000);
    trig = 0;
    chk(16'(st), 16'(1 << cur));
    for (int c = 0; c < 8; c++) chk(result[c*16+:16], 16'(cur == 0 ? -3 - c : (3 - c) >>> 1));
    cur = (s == 3'h7) ? 0 : s;
    chk(16'(ratio_log2), 16'(cur));
    while (w < TRIG_GAP * n) begin
      @(posedge ref_clk) #1 w++;
    end
  endtask
  task automatic t_ratios;
    logic [2:0] s;
    s = 3'h1;
    repeat (8) begin
      conv(s);
      s++;
    end
    $display("t_ratios done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 arst_n = 1;
    t_ratios;
    report_and_stop;
  end
  initial begin
    #40000;
    failures++;
    report_and_stop;
  end
endmodule
